// >>> crs_pkg.sv
// Shared constants and types of the clock reset sequencer and trim block.
package crs_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_CTRL       = 6'h30;
    localparam logic [5:0] IDX_IRQ_STAT   = 6'h31;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h32;
    localparam logic [5:0] IDX_RST_INFO   = 6'h33;
    localparam logic [5:0] IDX_TRIM_HIGH  = 6'h38;
    localparam logic [5:0] IDX_TRIM_LOW   = 6'h39;
    localparam logic [5:0] IDX_TEST_ZERO  = 6'h3A;
    localparam logic [5:0] IDX_TEST_UNDEF = 6'h3B;

    // Field positions.
    localparam int CTRL_OSC_ON_BIT  = 0;
    localparam int CTRL_LOCK_IE_BIT = 1;
    localparam int STAT_LOCK_CHG_BIT = 0;
    localparam int INFO_LOCKED_BIT  = 0;
    localparam int INFO_VEC_LSB     = 1;

    // Reset values and fixed read values.
    localparam logic [1:0] CTRL_RESET      = 2'h0;
    localparam logic [0:0] IRQ_RESET       = 1'h0;
    localparam logic [7:0] TEST_ZERO_VALUE = 8'h00;
    // Arbitrary value returned by the undefined test register.
    localparam logic [7:0] TEST_UNDEF_VALUE = 8'h00;
    localparam logic [8:0] TRIM_RESET      = 9'h000;

    // Sequence lengths in core oscillator cycles.
    localparam logic [9:0] SEQ_DRIVE_CYC  = 10'd516;
    localparam logic [9:0] SEQ_SETTLE_CYC = 10'd256;
    localparam logic [9:0] SEQ_TOTAL_CYC  = SEQ_DRIVE_CYC + SEQ_SETTLE_CYC;

    typedef enum logic [1:0] {
        VEC_POR_EXT  = 2'b00,
        VEC_OSC_FAIL = 2'b01,
        VEC_WDOG     = 2'b10
    } crs_vec_type;

    typedef enum logic [1:0] {
        SEQ_RUN    = 2'b00,
        SEQ_DRIVE  = 2'b01,
        SEQ_SETTLE = 2'b10,
        SEQ_HOLD   = 2'b11
    } crs_seq_type;

endpackage

// >>> crs_trim_if.sv
// Interface between the register front end and the trim holder.
`timescale 1ns/10ps
interface crs_trim_if;
    logic       wr_high;
    logic       wr_low;
    logic [7:0] wdata;
    logic [8:0] trim;
    logic       locked;
    logic       lock_chg;

    modport ctl  (output wr_high, output wr_low, output wdata,
                  input trim, input locked, input lock_chg);
    modport hold (input wr_high, input wr_low, input wdata,
                  output trim, output locked, output lock_chg);
endinterface

// >>> crs_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
module crs_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output      logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

// >>> crs_trim.sv
// Reference trim holder with lock status tracking.
`timescale 1ns/10ps
module crs_trim
    import crs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sys_rst_n,
    input  wire logic [8:0] factory_trim,
    input  wire logic       fll_locked,
    crs_trim_if.hold        bus
);
    logic [8:0] trim_ff;
    logic [8:0] nxt_trim;
    logic       load_pend_ff;
    logic       locked_ff;
    logic       nxt_locked;
    logic       chg_ff;
    logic       wclr_ff;
    logic       trim_wr;
    logic       load_now;

    assign trim_wr  = bus.wr_high | bus.wr_low;
    // The factory value lands on the first edge after system reset lifts.
    assign load_now = load_pend_ff & sys_rst_n;

    always_comb begin
        nxt_trim = trim_ff;
        if (load_now) begin
            nxt_trim = factory_trim;
        end
        if (bus.wr_high) begin
            nxt_trim[8] = bus.wdata[0];
        end
        if (bus.wr_low) begin
            nxt_trim[7:0] = bus.wdata;
        end
    end

    // A trim write forces unlock and keeps it until the loop drops lock,
    // so the write itself never shows up as a lock change.
    assign nxt_locked = (trim_wr | wclr_ff) ? 1'b0 : fll_locked;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_ff      <= TRIM_RESET;
            load_pend_ff <= 1'b1;
            locked_ff    <= 1'b0;
            chg_ff       <= 1'b0;
            wclr_ff      <= 1'b0;
        end else begin
            trim_ff      <= nxt_trim;
            load_pend_ff <= ~sys_rst_n;
            locked_ff    <= nxt_locked;
            chg_ff       <= ~trim_wr & (nxt_locked != locked_ff);
            wclr_ff      <= trim_wr | (wclr_ff & fll_locked);
        end
    end

    // Lower code means a faster reference; bits are binary weighted.
    assign bus.trim     = trim_ff;
    assign bus.locked   = locked_ff;
    assign bus.lock_chg = chg_ff;
endmodule

// >>> crs_top.sv
// Reset sequencer, reference trim registers and lock interrupt.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps

module crs_top
    import crs_pkg::*;
(
    // Clock and power-on reset.
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // Avalon-MM register slave.
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output      logic [31:0] AVS_READDATA,
    output      logic        AVS_WAITREQUEST,
    // Interrupt request.
    output      logic        IRQ,
    // Bidirectional reset pin.
    input  wire logic        RESET_PIN_IN,
    output      logic        RESET_PIN_OUT,
    output      logic        RESET_PIN_OE,
    // Reset sources.
    input  wire logic        ILLEGAL_ADDR,
    input  wire logic        WDOG_TIMEOUT,
    input  wire logic        OSC_MON_FAIL,
    // Core reset and vector choice.
    output      logic        CORE_RST_N,
    output      logic [1:0]  RESET_VECTOR,
    // Trim and oscillator control.
    input  wire logic [8:0]  FACTORY_TRIM,
    output      logic [8:0]  REF_TRIM,
    input  wire logic        FLL_LOCKED,
    output      logic        XTAL_OSC_ON
);

    crs_trim_if trim_bus ();

    // Bus front end.
    logic        waitreq_ff;
    logic        nxt_waitreq;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [5:0]  idx;
    logic        aligned;
    logic        req;
    logic        wr_commit;
    logic        lane0;
    logic [7:0]  wbyte;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_mask;
    logic        hit_info;
    logic        hit_trh;
    logic        hit_trl;
    logic        hit_t0;
    logic        hit_t1;
    logic [7:0]  rd_byte;

    // Control and interrupt state.
    logic [1:0]  ctrl_ff;
    logic [1:0]  nxt_ctrl;
    logic [0:0]  stat_ff;
    logic [0:0]  nxt_stat;
    logic [0:0]  mask_ff;
    logic [0:0]  nxt_mask;
    logic        irq_ff;
    logic        nxt_irq;
    logic        osc_on;
    logic        lock_ie;

    // Reset sequencer state.
    crs_seq_type state_ff;
    crs_seq_type nxt_state;
    logic [9:0]  cnt_ff;
    logic [9:0]  nxt_cnt;
    logic        oe_ff;
    logic        core_rst_n_ff;
    crs_vec_type vec_ff;
    crs_vec_type nxt_vec;
    logic        osc_pend_ff;
    logic        wdog_pend_ff;
    logic        seq_rst_n;
    logic        osc_fail_req;
    logic [2:0]  src_sync;
    logic        pin_s;
    logic        drive_end;
    logic        settle_end;
    logic        decide;
    crs_vec_type pick_vec;

    // Address decode.
    assign idx       = AVS_ADDRESS[7:2];
    assign aligned   = AVS_ADDRESS[1:0] == 2'b00;
    assign req       = AVS_READ | AVS_WRITE;
    assign wr_commit = AVS_WRITE & ~waitreq_ff;
    assign lane0     = wr_commit & AVS_BYTEENABLE[0];
    assign wbyte     = AVS_WRITEDATA[7:0];
    assign hit_ctrl  = aligned & (idx == IDX_CTRL);
    assign hit_stat  = aligned & (idx == IDX_IRQ_STAT);
    assign hit_mask  = aligned & (idx == IDX_IRQ_MASK);
    assign hit_info  = aligned & (idx == IDX_RST_INFO);
    assign hit_trh   = aligned & (idx == IDX_TRIM_HIGH);
    assign hit_trl   = aligned & (idx == IDX_TRIM_LOW);
    assign hit_t0    = aligned & (idx == IDX_TEST_ZERO);
    assign hit_t1    = aligned & (idx == IDX_TEST_UNDEF);

    assign osc_on  = ctrl_ff[CTRL_OSC_ON_BIT];
    assign lock_ie = ctrl_ff[CTRL_LOCK_IE_BIT];

    // Trim writes go out as one-cycle strobes.
    assign trim_bus.wr_high = lane0 & hit_trh;
    assign trim_bus.wr_low  = lane0 & hit_trl;
    assign trim_bus.wdata   = wbyte;

    // Read multiplexer; unmapped and test addresses return fixed bytes.
    always_comb begin
        rd_byte = 8'h00;
        if (hit_ctrl) begin
            rd_byte = {6'h00, ctrl_ff};
        end else if (hit_stat) begin
            rd_byte = {7'h00, stat_ff};
        end else if (hit_mask) begin
            rd_byte = {7'h00, mask_ff};
        end else if (hit_info) begin
            rd_byte = {5'h00, vec_ff, trim_bus.locked};
        end else if (hit_trh) begin
            rd_byte = {7'h00, trim_bus.trim[8]};
        end else if (hit_trl) begin
            rd_byte = trim_bus.trim[7:0];
        end else if (hit_t0) begin
            rd_byte = TEST_ZERO_VALUE;
        end else if (hit_t1) begin
            rd_byte = TEST_UNDEF_VALUE;
        end
    end

    // Every request is answered one edge after it is seen.
    assign nxt_waitreq = ~(req & waitreq_ff);
    assign nxt_rdata   = (AVS_READ & waitreq_ff) ? {24'h00_0000, rd_byte}
                                                 : rdata_ff;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            waitreq_ff <= 1'b1;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            waitreq_ff <= nxt_waitreq;
            rdata_ff   <= nxt_rdata;
        end
    end

    // Control, status and mask; test registers simply drop writes.
    assign nxt_ctrl = (lane0 & hit_ctrl) ? wbyte[1:0] : ctrl_ff;
    assign nxt_mask = (lane0 & hit_mask) ? wbyte[0:0] : mask_ff;

    // A lock change in the same cycle as a clearing write is kept.
    assign nxt_stat = (stat_ff & ~((lane0 & hit_stat) ? wbyte[0:0] : 1'b0))
                    | trim_bus.lock_chg;

    // The core masks this further with its own interrupt mask.
    assign nxt_irq = |(nxt_stat & nxt_mask) & nxt_ctrl[CTRL_LOCK_IE_BIT];

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_ff <= CTRL_RESET;
            stat_ff <= IRQ_RESET;
            mask_ff <= IRQ_RESET;
            irq_ff  <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            irq_ff  <= nxt_irq;
        end
    end

    // Source and pin synchronisers; pin idles high.
    crs_sync #(
        .WIDTH (3),
        .INIT  (3'b001)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst_n(RST_N),
        .din  ({OSC_MON_FAIL, WDOG_TIMEOUT, RESET_PIN_IN}),
        .dout (src_sync)
    );

    assign pin_s = src_sync[0];

    // Entry needs no clock: any internal source, the oscillator fail only while osc_on is set,
    // clears the sequencer directly. Glitches on these sources therefore also reset the part.
    assign osc_fail_req = OSC_MON_FAIL & osc_on;
    assign seq_rst_n = RST_N & ~ILLEGAL_ADDR & ~WDOG_TIMEOUT
                     & ~osc_fail_req;

    assign drive_end  = cnt_ff == SEQ_DRIVE_CYC - 10'd1;
    assign settle_end = cnt_ff == SEQ_TOTAL_CYC - 10'd1;
    assign decide     = (state_ff == SEQ_SETTLE) & settle_end;

    assign pick_vec = !pin_s       ? VEC_POR_EXT
                    : osc_pend_ff  ? VEC_OSC_FAIL
                    : wdog_pend_ff ? VEC_WDOG
                    : VEC_POR_EXT;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            SEQ_RUN: begin
                nxt_cnt = 10'd0;
                if (!pin_s) begin
                    nxt_state = SEQ_DRIVE;
                end
            end
            SEQ_DRIVE: begin
                nxt_cnt = cnt_ff + 10'd1;
                if (drive_end) begin
                    nxt_state = SEQ_SETTLE;
                end
            end
            SEQ_SETTLE: begin
                nxt_cnt = cnt_ff + 10'd1;
                if (settle_end) begin
                    nxt_state = pin_s ? SEQ_RUN : SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                nxt_cnt = 10'd0;
                if (pin_s) begin
                    nxt_state = SEQ_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            state_ff      <= SEQ_DRIVE;
            cnt_ff        <= 10'd0;
            oe_ff         <= 1'b1;
            core_rst_n_ff <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            oe_ff         <= nxt_state == SEQ_DRIVE;
            core_rst_n_ff <= nxt_state == SEQ_RUN;
        end
    end

    // Pending causes survive the sequence and both clear at the decision, whichever vector is picked;
    // a cause arriving on the deciding edge is kept.
    assign nxt_vec = decide ? pick_vec : vec_ff;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_pend_ff  <= 1'b0;
            wdog_pend_ff <= 1'b0;
            vec_ff       <= VEC_POR_EXT;
        end else begin
            osc_pend_ff  <= (src_sync[2] & osc_on) | (osc_pend_ff & ~decide);
            wdog_pend_ff <= src_sync[1] | (wdog_pend_ff & ~decide);
            vec_ff       <= nxt_vec;
        end
    end

    crs_trim u_trim (
        .clk         (CORE_CLK),
        .rst_n       (RST_N),
        .sys_rst_n   (core_rst_n_ff),
        .factory_trim(FACTORY_TRIM),
        .fll_locked  (FLL_LOCKED),
        .bus         (trim_bus.hold)
    );

    // Outputs.
    assign AVS_READDATA    = rdata_ff;
    assign AVS_WAITREQUEST = waitreq_ff;
    assign IRQ             = irq_ff;
    assign RESET_PIN_OUT   = 1'b0;
    assign RESET_PIN_OE    = oe_ff;
    assign CORE_RST_N      = core_rst_n_ff;
    assign RESET_VECTOR    = vec_ff;
    assign REF_TRIM        = trim_bus.trim;
    assign XTAL_OSC_ON     = osc_on;

endmodule

// >>> crs_pin_model.sv
// Reset pin wire with its pull-up and an external pull-down driver.
`timescale 1ns/10ps
module crs_pin_model (
    // Device side of the pin.
    input  wire logic drive_en,
    input  wire logic drive_val,
    // External circuitry.
    input  wire logic ext_pull,
    output      logic pin_level
);
    // The pull-up restores a high level once nobody drives the pin.
    assign pin_level = (drive_en ? drive_val : 1'b1) & ~ext_pull;
endmodule

// >>> crs_checker.sv
// Concurrent checks on the sequencer top-level ports.
`timescale 1ns/10ps
module crs_checker (
    // Clock, reset and bus.
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic        AVS_WAITREQUEST,
    // Reset pin and sources.
    input wire logic        RESET_PIN_IN,
    input wire logic        RESET_PIN_OE,
    input wire logic        RESET_PIN_OUT,
    input wire logic        ILLEGAL_ADDR,
    input wire logic        WDOG_TIMEOUT,
    input wire logic        OSC_MON_FAIL,
    // Core side and trim.
    input wire logic        CORE_RST_N,
    input wire logic [1:0]  RESET_VECTOR,
    input wire logic [8:0]  FACTORY_TRIM,
    input wire logic [8:0]  REF_TRIM,
    input wire logic        XTAL_OSC_ON
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    logic       src_any;
    logic [9:0] oe_cnt_ff;
    assign src_any = WDOG_TIMEOUT | ILLEGAL_ADDR | (OSC_MON_FAIL & XTAL_OSC_ON);

    // Counting restarts while a source holds the sequencer in reset.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            oe_cnt_ff <= 10'h000;
        end else if (RESET_PIN_OE && !src_any) begin
            oe_cnt_ff <= oe_cnt_ff + 10'h001;
        end else begin
            oe_cnt_ff <= 10'h000;
        end
    end

    sequence s_answer;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence

    // The pin is sampled through the two-flop synchroniser at the decision.
    sequence s_settle;
        ##255 !CORE_RST_N ##1 (CORE_RST_N == $past(RESET_PIN_IN, 3));
    endsequence

    a_drive_len: assert property ($fell(RESET_PIN_OE) |->
        oe_cnt_ff >= 10'h203 && oe_cnt_ff <= 10'h206)
        else $error("pin drive length wrong");
    a_pin_low: assert property (RESET_PIN_OE |-> !RESET_PIN_OUT)
        else $error("pin driven high");
    a_core_held: assert property (RESET_PIN_OE |-> !CORE_RST_N)
        else $error("core released while pin driven");
    a_settle_wait: assert property ($fell(RESET_PIN_OE) |->
        s_settle)
        else $error("settle wait length wrong");
    a_src_entry: assert property (src_any |->
        RESET_PIN_OE && !CORE_RST_N)
        else $error("reset source not entered");
    a_osc_gated: assert property (OSC_MON_FAIL && !XTAL_OSC_ON
        && $past(CORE_RST_N) && RESET_PIN_IN |-> CORE_RST_N)
        else $error("oscillator fail acted while off");
    a_ext_entry: assert property ($fell(RESET_PIN_IN)
        && !RESET_PIN_OE |-> ##[1:4] RESET_PIN_OE)
        else $error("external reset not entered");
    a_vec_stable: assert property (CORE_RST_N && $past(CORE_RST_N)
        |-> $stable(RESET_VECTOR))
        else $error("vector changed while running");
    a_trim_load: assert property ($rose(CORE_RST_N) |->
        ##[1:3] REF_TRIM == FACTORY_TRIM)
        else $error("factory trim not loaded");
    a_bus_answer: assert property ((AVS_READ || AVS_WRITE)
        && AVS_WAITREQUEST |=> s_answer)
        else $error("bus answer late");
endmodule

// >>> tb_top.sv
// Self-checking bench for the clock reset sequencer.
`timescale 1ns/10ps
module tb_top
    import crs_pkg::*;
;
    localparam int SEQ_N = int'(SEQ_TOTAL_CYC) + 1;

    logic        core_clk;
    logic        rst_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe;
    logic        illegal_addr;
    logic        wdog_timeout;
    logic        osc_mon_fail;
    logic        core_rst_n;
    logic [1:0]  reset_vector;
    logic [8:0]  factory_trim;
    logic [8:0]  ref_trim;
    logic        fll_locked;
    logic        xtal_osc_on;
    logic        ext_pull;
    int          err_total;
    int          n_tests;
    int          cyc;

    crs_top DUT (
        .CORE_CLK        (core_clk),
        .RST_N           (rst_n),
        .AVS_ADDRESS     (avs_address),
        .AVS_READ        (avs_read),
        .AVS_WRITE       (avs_write),
        .AVS_WRITEDATA   (avs_writedata),
        .AVS_BYTEENABLE  (4'h1),
        .AVS_READDATA    (avs_readdata),
        .AVS_WAITREQUEST (avs_waitrequest),
        .IRQ             (irq),
        .RESET_PIN_IN    (pin_in),
        .RESET_PIN_OUT   (pin_out),
        .RESET_PIN_OE    (pin_oe),
        .ILLEGAL_ADDR    (illegal_addr),
        .WDOG_TIMEOUT    (wdog_timeout),
        .OSC_MON_FAIL    (osc_mon_fail),
        .CORE_RST_N      (core_rst_n),
        .RESET_VECTOR    (reset_vector),
        .FACTORY_TRIM    (factory_trim),
        .REF_TRIM        (ref_trim),
        .FLL_LOCKED      (fll_locked),
        .XTAL_OSC_ON     (xtal_osc_on)
    );

    crs_pin_model u_pin (
        .drive_en  (pin_oe),
        .drive_val (pin_out),
        .ext_pull  (ext_pull),
        .pin_level (pin_in)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic end_of_test;
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The whole run needs about 4300 cycles; over twice that means a hang.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic check(input string nm, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // The request stays up until the edge that samples waitrequest low.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        // Only the bench timeout ends a wait that never gets an answer.
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wait_core(output int n);
        n = 0;
        while (core_rst_n !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    // Pulses of four cycles are long enough to be recorded as pending.
    task automatic pulse(input logic [2:0] m);
        @(posedge core_clk);
        {osc_mon_fail, wdog_timeout, illegal_addr} <= m;
        repeat (4) @(posedge core_clk);
        {osc_mon_fail, wdog_timeout, illegal_addr} <= 3'b000;
    endtask

    task automatic seq_done(input logic [1:0] vec);
        int n;
        logic [7:0] q;
        logic ok;
        wait_core(n);
        ok = n >= SEQ_N - 1 && n <= SEQ_N + 1;
        check("release", 32'h1, 32'(ok));
        repeat (3) @(posedge core_clk);
        check("trim load", 32'(factory_trim), 32'(ref_trim));
        check("vector", 32'(vec), 32'(reset_vector));
        bus(1'b0, 8'hCC, 8'h00, q);
        check("info vector", 32'(vec), 32'(q[2:1]));
    endtask

    task automatic t_regs;
        logic [7:0] q;
        bus(1'b1, 8'hE0, 8'hFF, q);
        bus(1'b1, 8'hE4, 8'h5A, q);
        bus(1'b0, 8'hE0, 8'h00, q);
        check("trim high", 32'h1, 32'(q));
        bus(1'b0, 8'hE4, 8'h00, q);
        check("trim low", 32'h5A, 32'(q));
        check("trim out", 32'h15A, 32'(ref_trim));
        bus(1'b1, 8'hE8, 8'hFF, q);
        bus(1'b0, 8'hE8, 8'h00, q);
        check("test zero", 32'h0, 32'(q));
        bus(1'b1, 8'hEC, 8'h55, q);
        bus(1'b0, 8'hEC, 8'h00, q);
        check("test undef", 32'(TEST_UNDEF_VALUE), 32'(q));
        bus(1'b1, 8'h04, 8'hFF, q);
        bus(1'b0, 8'h04, 8'h00, q);
        check("unmapped", 32'h0, 32'(q));
    endtask

    task automatic t_lock;
        logic [7:0] q;
        bus(1'b1, 8'hC0, 8'h02, q);
        bus(1'b1, 8'hC8, 8'h01, q);
        fll_locked <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("irq lock", 32'h1, 32'(irq));
        bus(1'b1, 8'hC8, 8'h00, q);
        repeat (2) @(posedge core_clk);
        check("irq masked", 32'h0, 32'(irq));
        bus(1'b1, 8'hC4, 8'h01, q);
        bus(1'b0, 8'hC4, 8'h00, q);
        check("flag clear", 32'h0, 32'(q));
        fll_locked <= 1'b0;
        repeat (4) @(posedge core_clk);
        bus(1'b0, 8'hC4, 8'h00, q);
        check("flag unlock", 32'h1, 32'(q));
        bus(1'b1, 8'hC8, 8'h01, q);
        repeat (2) @(posedge core_clk);
        check("irq unlock", 32'h1, 32'(irq));
        bus(1'b1, 8'hC0, 8'h00, q);
        repeat (2) @(posedge core_clk);
        check("irq disabled", 32'h0, 32'(irq));
        bus(1'b1, 8'hC4, 8'h01, q);
        // A trim write while locked drops the status but raises no flag.
        fll_locked <= 1'b1;
        repeat (4) @(posedge core_clk);
        bus(1'b1, 8'hC4, 8'h01, q);
        bus(1'b1, 8'hE4, 8'h5A, q);
        repeat (4) @(posedge core_clk);
        bus(1'b0, 8'hCC, 8'h00, q);
        check("lock cleared", 32'h0, 32'(q[0]));
        bus(1'b0, 8'hC4, 8'h00, q);
        check("flag kept", 32'h0, 32'(q));
        fll_locked <= 1'b0;
    endtask

    task automatic t_osc;
        logic [7:0] q;
        pulse(3'b100);
        check("osc off core", 32'h1, 32'(core_rst_n));
        bus(1'b1, 8'hC0, 8'h01, q);
        @(posedge core_clk);
        check("osc on", 32'h1, 32'(xtal_osc_on));
        pulse(3'b010);
        seq_done(VEC_WDOG);
        pulse(3'b110);
        seq_done(VEC_OSC_FAIL);
        bus(1'b1, 8'hC0, 8'h00, q);
        @(posedge core_clk);
        check("osc off", 32'h0, 32'(xtal_osc_on));
    endtask

    task automatic t_ext;
        int n;
        ext_pull <= 1'b1;
        repeat (1000) @(posedge core_clk);
        check("held core", 32'h0, 32'(core_rst_n));
        check("drive off", 32'h0, 32'(pin_oe));
        ext_pull <= 1'b0;
        wait_core(n);
        check("late release", 32'h1, 32'(n <= 8));
        check("ext vector", 32'(VEC_POR_EXT), 32'(reset_vector));
    endtask

    initial begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        {osc_mon_fail, wdog_timeout, illegal_addr} = 3'b000;
        factory_trim = 9'h1A5;
        fll_locked = 1'b0;
        ext_pull = 1'b0;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        seq_done(VEC_POR_EXT);
        t_regs();
        t_lock();
        t_osc();
        pulse(3'b001);
        seq_done(VEC_POR_EXT);
        t_ext();
        end_of_test();
    end
endmodule

bind crs_top crs_checker u_chk (.*);
